/* File: afc_pkg.sv */
// Package for the front-end configuration and calibration register bank.
// Assumes an 8-bit register port driven by the serial command decoder.
package afc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int WORD_W = 24;
  localparam logic [3:0] ADDR_MAIN = 4'h1;
  localparam logic [3:0] ADDR_FE = 4'h2;
  localparam logic [3:0] ADDR_HP_LO = 4'h3;
  localparam logic [3:0] ADDR_HP_HI = 4'h4;
  localparam logic [3:0] ADDR_OFS_LO = 4'h5;
  localparam logic [3:0] ADDR_OFS_MID = 4'h6;
  localparam logic [3:0] ADDR_OFS_HI = 4'h7;
  localparam logic [3:0] ADDR_GAIN_LO = 4'h8;
  localparam logic [3:0] ADDR_GAIN_MID = 4'h9;
  localparam logic [3:0] ADDR_GAIN_HI = 4'hA;
  localparam logic [7:0] RST_MAIN = 8'h52;
  localparam logic [7:0] RST_FE = 8'h08;
  localparam logic [7:0] RST_HP_LO = 8'h32;
  localparam logic [7:0] RST_HP_HI = 8'h03;
  localparam logic [7:0] RST_OFS_BYTE = 8'h00;
  localparam logic [7:0] RST_GAIN_LO = 8'h00;
  localparam logic [7:0] RST_GAIN_MID = 8'h00;
  localparam logic [7:0] RST_GAIN_HI = 8'h40;
  localparam int FE_SEL_LSB = 4;
  localparam int FE_AMP_ENABLE_A_BIT = 3;
  localparam int FE_GAIN_LSB = 0;
  localparam logic [7:0] FE_WMASK = 8'h7F;
  localparam logic [1:0] FILT_SINC_ONLY = 2'h1;
  localparam int GAIN_SHIFT = 22;
  localparam int OFS_SHIFT = 8;
  localparam logic [5:0] RESTART_READS = 6'd63;
  localparam logic [2:0] GAIN_MAX_CODE = 3'h6;
endpackage : afc_pkg

/* File: afc_regbank.sv */
// Register bank and offset/gain scaling path of the converter core.
// Assumes the command decoder hands over single byte writes and reads,
// one per cycle, and the filter presents results with a one-cycle strobe.
`timescale 1ns/1ps

// Overview of operation
// - Input select bits 6:4 pick pair 1, pair 2, short, tied, or neg short.
// - Bit 3 enables amplifier chopping; enabled after reset.
// - Gain bits 2:0 select 1 to 64 in powers of two.
// - High-pass corner word is low byte at 03h, high byte at 04h.
// - Offset word bytes go low, mid, high by rising address.
// - Offset is shifted left eight bits against the 32-bit result.
// - Offset is two's complement; zero means no correction, reset zero.
// - Output equals filter data minus offset, times gain over 400000h.
// - Gain word is unsigned, 400000h meaning unity.
// - Gain word bytes go low, mid, high by rising address.
// - Offset and gain load by host write or calibration engine.
// - Sinc-only filter path skips the offset and gain stage.
// - Filter select code 01 means sinc-only path.
// - Any register write restarts conversion, dropping 63 readings.
// - Registers are reached only by register read and write commands, apart from calibration loads of offset and gain.
module afc_regbank (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [afc_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic CAL_OFS_LOAD,
  input wire logic [afc_pkg::WORD_W-1:0] CAL_OFS_WORD,
  input wire logic CAL_GAIN_LOAD,
  input wire logic [afc_pkg::WORD_W-1:0] CAL_GAIN_WORD,
  input wire logic FILT_VALID,
  input wire logic [afc_pkg::DATA_W-1:0] FILT_DATA,
  output logic [afc_pkg::DATA_W-1:0] OUT_DATA,
  output logic OUT_VALID,
  output logic CONV_RESTART,
  output logic [2:0] INPUT_SELECT,
  output logic [4:0] INPUT_ROUTE,
  output logic AMP_ENABLE_A,
  output logic [6:0] AMP_GAIN,
  output logic [15:0] HP_CORNER_WORD,
  output logic [1:0] FILTER_PATH_SELECT
);
  import afc_pkg::*;

  logic [7:0] main_r, main_nxt;
  logic [7:0] fe_r, fe_nxt;
  logic [15:0] hp_r, hp_nxt;
  logic [WORD_W-1:0] ofs_r, ofs_nxt;
  logic [WORD_W-1:0] gain_r, gain_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic restart_r, restart_nxt;
  logic [5:0] skip_r, skip_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic [4:0] route_r, route_nxt;
  logic amp_enable_a_r, amp_enable_a_nxt;
  logic [6:0] amp_r, amp_nxt;
  logic [DATA_W-1:0] out_r, out_nxt;
  logic ovalid_r, ovalid_nxt;
  logic sinc_only;
  logic signed [DATA_W:0] diff;
  logic signed [DATA_W+WORD_W+1:0] prod;
  logic signed [DATA_W+WORD_W+1:0] scaled;

  assign sinc_only = (main_r[1:0] == FILT_SINC_ONLY);

  // Register file; a host write wins over a calibration load in the same
  // cycle because the host expects to read back what it wrote.
  always_comb begin
    main_nxt = main_r;
    fe_nxt = fe_r;
    hp_nxt = hp_r;
    ofs_nxt = ofs_r;
    gain_nxt = gain_r;
    if (CAL_OFS_LOAD) begin
      ofs_nxt = CAL_OFS_WORD;
    end
    if (CAL_GAIN_LOAD) begin
      gain_nxt = CAL_GAIN_WORD;
    end
    if (REG_WR) begin
      unique case (REG_ADDR)
        ADDR_MAIN: main_nxt = REG_WDATA;
        ADDR_FE: fe_nxt = REG_WDATA & FE_WMASK;
        ADDR_HP_LO: hp_nxt[7:0] = REG_WDATA;
        ADDR_HP_HI: hp_nxt[15:8] = REG_WDATA;
        ADDR_OFS_LO: ofs_nxt[7:0] = REG_WDATA;
        ADDR_OFS_MID: ofs_nxt[15:8] = REG_WDATA;
        ADDR_OFS_HI: ofs_nxt[23:16] = REG_WDATA;
        ADDR_GAIN_LO: gain_nxt[7:0] = REG_WDATA;
        ADDR_GAIN_MID: gain_nxt[15:8] = REG_WDATA;
        ADDR_GAIN_HI: gain_nxt[23:16] = REG_WDATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      main_r <= RST_MAIN;
      fe_r <= RST_FE;
      hp_r <= {RST_HP_HI, RST_HP_LO};
      ofs_r <= {RST_OFS_BYTE, RST_OFS_BYTE, RST_OFS_BYTE};
      gain_r <= {RST_GAIN_HI, RST_GAIN_MID, RST_GAIN_LO};
    end else begin
      main_r <= main_nxt;
      fe_r <= fe_nxt;
      hp_r <= hp_nxt;
      ofs_r <= ofs_nxt;
      gain_r <= gain_nxt;
    end
  end

  // Read port and front-end decode, all registered.
  always_comb begin
    rvalid_nxt = REG_RD;
    rdata_nxt = rdata_r;
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_MAIN: rdata_nxt = main_r;
        ADDR_FE: rdata_nxt = fe_r;
        ADDR_HP_LO: rdata_nxt = hp_r[7:0];
        ADDR_HP_HI: rdata_nxt = hp_r[15:8];
        ADDR_OFS_LO: rdata_nxt = ofs_r[7:0];
        ADDR_OFS_MID: rdata_nxt = ofs_r[15:8];
        ADDR_OFS_HI: rdata_nxt = ofs_r[23:16];
        ADDR_GAIN_LO: rdata_nxt = gain_r[7:0];
        ADDR_GAIN_MID: rdata_nxt = gain_r[15:8];
        ADDR_GAIN_HI: rdata_nxt = gain_r[23:16];
        default: rdata_nxt = 8'h00;
      endcase
    end
    sel_nxt = fe_r[FE_SEL_LSB +: 3];
    // One-hot route: pair1, pair2, internal short, tied, negative short.
    route_nxt = 5'h00;
    if (sel_nxt <= 3'h4) begin
      route_nxt[sel_nxt] = 1'b1;
    end
    amp_enable_a_nxt = fe_r[FE_AMP_ENABLE_A_BIT];
    // Codes above the top code are held at the top gain.
    amp_nxt = 7'h01;
    if (fe_r[FE_GAIN_LSB +: 3] > GAIN_MAX_CODE) begin
      amp_nxt = 7'h40;
    end else begin
      amp_nxt = 7'h01 << fe_r[FE_GAIN_LSB +: 3];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      sel_r <= 3'h0;
      route_r <= 5'h01;
      amp_enable_a_r <= 1'b1;
      amp_r <= 7'h01;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      sel_r <= sel_nxt;
      route_r <= route_nxt;
      amp_enable_a_r <= amp_enable_a_nxt;
      amp_r <= amp_nxt;
    end
  end

  // Scaling: 33-bit difference times unsigned gain, shifted by 22 bits.
  assign diff = $signed({FILT_DATA[DATA_W-1], FILT_DATA})
              - $signed({ofs_r[WORD_W-1], ofs_r, 8'h00});
  assign prod = diff * $signed({1'b0, gain_r});
  assign scaled = prod >>> GAIN_SHIFT;

  // After a write the next 63 filter results are discarded while the
  // conversion chain refills; a further write restarts the count.
  always_comb begin
    restart_nxt = REG_WR;
    skip_nxt = skip_r;
    ovalid_nxt = 1'b0;
    out_nxt = out_r;
    if (REG_WR) begin
      skip_nxt = RESTART_READS;
    end else if (FILT_VALID) begin
      if (skip_r != 6'd0) begin
        skip_nxt = skip_r - 6'd1;
      end else begin
        ovalid_nxt = 1'b1;
        if (sinc_only) begin
          out_nxt = FILT_DATA;
        end else if (scaled > $signed({{WORD_W+2{1'b0}}, 32'h7FFF_FFFF})) begin
          out_nxt = 32'h7FFF_FFFF;
        end else if (scaled < $signed({{WORD_W+2{1'b1}}, 32'h8000_0000})) begin
          out_nxt = 32'h8000_0000;
        end else begin
          out_nxt = scaled[DATA_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      restart_r <= 1'b0;
      skip_r <= 6'd0;
      ovalid_r <= 1'b0;
      out_r <= 32'h0000_0000;
    end else begin
      restart_r <= restart_nxt;
      skip_r <= skip_nxt;
      ovalid_r <= ovalid_nxt;
      out_r <= out_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign REG_RVALID = rvalid_r;
  assign OUT_DATA = out_r;
  assign OUT_VALID = ovalid_r;
  assign CONV_RESTART = restart_r;
  assign INPUT_SELECT = sel_r;
  assign INPUT_ROUTE = route_r;
  assign AMP_ENABLE_A = amp_enable_a_r;
  assign AMP_GAIN = amp_r;
  assign HP_CORNER_WORD = hp_r;
  assign FILTER_PATH_SELECT = main_r[1:0];

  a_write_restart: assert property (@(posedge CORE_CLK) disable iff (SRST)
    REG_WR |=> CONV_RESTART && skip_r == 6'd63)
    else $error("write did not restart conversion");
  a_skip_blocks: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (skip_r != 6'd0 || REG_WR) |=> !OUT_VALID)
    else $error("output during restart window");
  a_sinc_bypass: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (FILT_VALID && !REG_WR && skip_r == 6'd0 && sinc_only)
    |=> OUT_VALID && OUT_DATA == $past(FILT_DATA))
    else $error("sinc path not bypassed");
  a_unity_zero: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (FILT_VALID && !REG_WR && skip_r == 6'd0 && !sinc_only
     && ofs_r == 24'h00_0000 && gain_r == 24'h40_0000)
    |=> OUT_DATA == $past(FILT_DATA))
    else $error("unity scaling altered data");
  a_ofs_write: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (REG_WR && REG_ADDR == ADDR_OFS_HI && !CAL_OFS_LOAD)
    |=> ofs_r[23:16] == $past(REG_WDATA))
    else $error("offset high byte not stored");
  a_gain_cal: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (CAL_GAIN_LOAD && !REG_WR) |=> gain_r == $past(CAL_GAIN_WORD))
    else $error("calibration gain not loaded");
  a_hp_word: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (REG_WR && REG_ADDR == ADDR_HP_HI)
    |=> HP_CORNER_WORD[15:8] == $past(REG_WDATA))
    else $error("corner high byte wrong");
  a_amp_enable_a_follow: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (REG_WR && REG_ADDR == ADDR_FE) |=> ##1
    AMP_ENABLE_A == $past(REG_WDATA[3], 2)
    && AMP_GAIN == (($past(REG_WDATA[2:0], 2) > GAIN_MAX_CODE) ? 7'h40
    : (7'h01 << $past(REG_WDATA[2:0], 2))))
    else $error("front end decode wrong");
  a_route_onehot: assert property (@(posedge CORE_CLK) disable iff (SRST)
    INPUT_SELECT <= 3'h4 |-> $onehot(INPUT_ROUTE))
    else $error("route not one-hot");
  a_ofs_sign: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (FILT_VALID && !REG_WR && skip_r == 6'd0 && !sinc_only
     && ofs_r == 24'hFF_FFFF && gain_r == 24'h40_0000
     && FILT_DATA == 32'h0000_0000) |=> OUT_DATA == 32'h0000_0100)
    else $error("negative offset wrong");
  c_scaled_out: cover property (@(posedge CORE_CLK) OUT_VALID && !sinc_only);
  c_sinc_out: cover property (@(posedge CORE_CLK) OUT_VALID && sinc_only);
  c_clip_hi: cover property (@(posedge CORE_CLK)
    OUT_VALID && OUT_DATA == 32'h7FFF_FFFF);
  c_restart_end: cover property (@(posedge CORE_CLK)
    skip_r == 6'd1 && FILT_VALID);
endmodule : afc_regbank

/* File: afc_host.sv */
// Host model that issues single register reads and writes on the byte port.
// Assumes the bench calls its tasks and that it shares the core clock.
`timescale 1ns/1ps
module afc_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output logic wr,
  output logic rd,
  output logic [3:0] addr,
  output logic [7:0] wdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
  end

  // Address and data are inverted once released so stale values never match.
  task automatic write_byte(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : write_byte

  task automatic read_byte(input logic [3:0] a, output logic [7:0] d,
                           output logic ok);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    ok = rvalid;
    d = rdata;
  endtask : read_byte
endmodule : afc_host

/* File: test_afc_regbank.sv */
// Self-checking bench for the register bank and scaling path.
// Assumes the host model drives the register port; inputs change at negedge.
`timescale 1ns/1ps
module test_afc_regbank;
  import afc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr, reg_rd, rvalid, ofs_ld = 1'b0, gn_ld = 1'b0;
  logic fv = 1'b0, ov, restart, amp_enable_a;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [23:0] ofs_w = 24'h00_0000, gn_w = 24'h00_0000;
  logic [31:0] fd = 32'h0000_0000, od;
  logic [2:0] sel;
  logic [4:0] route;
  logic [6:0] gain;
  logic [15:0] hp;
  logic [1:0] path;
  int compares = 0, miscompares = 0;
  logic [7:0] rst_v [10] = '{8'h52, 8'h08, 8'h32, 8'h03, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h40};
  logic [23:0] ofs_v [6] = '{24'h00_0000, 24'h00_0001, 24'hFF_FFFF,
                             24'h00_0000, 24'h00_0000, 24'h80_0000};
  logic [23:0] gn_v [6] = '{24'h40_0000, 24'h40_0000, 24'h40_0000,
                            24'h80_0000, 24'h20_0000, 24'h40_0000};
  logic [31:0] in_v [6] = '{32'h0123_4567, 32'h0000_0000, 32'h0000_0000,
                            32'h4000_0000, 32'hFFFF_FFFD, 32'h0000_0000};

  always #12.5 clk = ~clk;

  afc_host host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .wr(reg_wr),
    .rd(reg_rd), .addr(addr), .wdata(wdata));
  afc_regbank uut (.CORE_CLK(clk), .SRST(srst), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .CAL_OFS_LOAD(ofs_ld), .CAL_OFS_WORD(ofs_w),
    .CAL_GAIN_LOAD(gn_ld), .CAL_GAIN_WORD(gn_w), .FILT_VALID(fv),
    .FILT_DATA(fd), .OUT_DATA(od), .OUT_VALID(ov), .CONV_RESTART(restart),
    .INPUT_SELECT(sel), .INPUT_ROUTE(route), .AMP_ENABLE_A(amp_enable_a),
    .AMP_GAIN(gain), .HP_CORNER_WORD(hp), .FILTER_PATH_SELECT(path));

  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic w(input logic [3:0] a, input logic [7:0] d);
    host.write_byte(a, d);
    chk(restart, 32'h1);
  endtask : w

  task automatic r(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.read_byte(a, d, ok);
    chk(ok, 32'h1);
    chk(d, exp);
    if (ok !== 1'b1)
      conclude;
  endtask : r

  // A wanted result that never arrives within three cycles ends the run.
  task automatic filt(input logic [31:0] x, input bit want,
                      output logic [31:0] y);
    bit got;
    got = 1'b0;
    @(negedge clk);
    fv = 1'b1;
    fd = x;
    for (int n = 0; n < 3; n++) begin
      @(negedge clk);
      fv = 1'b0;
      fd = ~x;
      if (ov === 1'b1) begin
        got = 1'b1;
        y = od;
      end
    end
    chk({31'h0, got}, {31'h0, want});
    if (want && !got)
      conclude;
  endtask : filt

  task automatic skip63;
    logic [31:0] y;
    repeat (63) filt(32'h0000_1111, 1'b0, y);
  endtask : skip63

  // Floor shift and 32-bit clipping give the expected scaled code.
  function automatic logic [31:0] scale(input logic [31:0] x,
      input logic [23:0] o, input logic [23:0] g);
    longint d;
    d = longint'(signed'(x)) - (longint'(signed'(o)) <<< 8);
    d = (d * longint'(g)) >>> 22;
    if (d > 64'sh0000_0000_7FFF_FFFF)
      return 32'h7FFF_FFFF;
    if (d < 64'shFFFF_FFFF_8000_0000)
      return 32'h8000_0000;
    return d[31:0];
  endfunction : scale

  task automatic t_reset;
    for (int i = 0; i < 10; i++)
      r(4'(i + 1), rst_v[i]);
    w(4'hB, 8'hFF);
    r(4'hB, 8'h00);
    chk(sel, 32'h0);
    chk(route, 32'h1);
    chk(gain, 32'h1);
    chk(amp_enable_a, 32'h1);
    chk(hp, 32'h0332);
    chk(path, 32'h2);
    $display("test reset done");
  endtask : t_reset

  task automatic t_front;
    for (int s = 0; s < 5; s++)
      for (int g = 0; g < 7; g++) begin
        w(4'h2, 8'({s[2:0], g[0], g[2:0]}));
        @(negedge clk);
        chk(sel, s);
        chk(route, 32'h1 << s);
        chk(amp_enable_a, g[0]);
        chk(gain, 32'h1 << g);
      end
    w(4'h2, 8'hFF);
    r(4'h2, 8'h7F);
    chk(route, 32'h0);
    chk(gain, 32'h40);
    w(4'h2, 8'h08);
    $display("test front_end done");
  endtask : t_front

  task automatic t_hp;
    w(4'h3, 8'hA5);
    w(4'h4, 8'h5A);
    chk(hp, 32'h5AA5);
    r(4'h4, 8'h5A);
    $display("test hp_corner done");
  endtask : t_hp

  task automatic t_scale;
    logic [31:0] y;
    for (int i = 0; i < 6; i++) begin
      w(4'h5, ofs_v[i][7:0]);
      w(4'h6, ofs_v[i][15:8]);
      w(4'h7, ofs_v[i][23:16]);
      w(4'h8, gn_v[i][7:0]);
      w(4'h9, gn_v[i][15:8]);
      w(4'hA, gn_v[i][23:16]);
      skip63;
      filt(in_v[i], 1'b1, y);
      chk(y, scale(in_v[i], ofs_v[i], gn_v[i]));
    end
    $display("test scaling done");
  endtask : t_scale

  task automatic t_cal;
    logic [31:0] y;
    @(negedge clk);
    ofs_ld = 1'b1;
    gn_ld = 1'b1;
    ofs_w = 24'h00_0010;
    gn_w = 24'h60_0000;
    @(negedge clk);
    ofs_ld = 1'b0;
    gn_ld = 1'b0;
    filt(32'h0000_3000, 1'b1, y);
    chk(y, scale(32'h0000_3000, 24'h00_0010, 24'h60_0000));
    r(4'h5, 8'h10);
    r(4'hA, 8'h60);
    $display("test cal_load done");
  endtask : t_cal

  task automatic t_sinc;
    logic [31:0] y;
    w(4'h1, 8'h51);
    chk(path, FILT_SINC_ONLY);
    skip63;
    filt(32'h8000_0001, 1'b1, y);
    chk(y, 32'h8000_0001);
    w(4'h1, 8'h52);
    $display("test sinc_bypass done");
  endtask : t_sinc

  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_reset;
    t_front;
    t_hp;
    t_scale;
    t_cal;
    t_sinc;
    conclude;
  end
endmodule : test_afc_regbank
